// >>> pll_lock_consts.svh
/*
 * Constants for the PLL lock detect and calibration control block:
 * register byte addresses, reset values, counts and window times.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef PLL_LOCK_CONSTS_SVH
`define PLL_LOCK_CONSTS_SVH

// ==========================================================
// Register map (byte addresses, one aligned word each)
`define CTRL_ADDR 12'h018
`define IRQ_STAT_ADDR 12'h020
`define IRQ_MASK_ADDR 12'h024
`define LOCK_STATE_ADDR 12'h028

// ==========================================================
// Reset values and write masks
`define CTRL_RESET 8'h06
`define CTRL_WMASK 8'hfe
`define IRQ_RESET 2'h0
`define IRQ_ACQ 2'h1
`define IRQ_LOSS 2'h2

// ==========================================================
// Consecutive in-window detector cycles needed for lock
`define LOCK_CNT_SEL0 8'h05
`define LOCK_CNT_SEL1 8'h10
`define LOCK_CNT_SEL2 8'h40
`define LOCK_CNT_SEL3 8'hff
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01

// ==========================================================
// Lock window times in picoseconds (3500 ps high range)
`define WIN_HIGH_PS 16'h0dac
`define WIN_LOW_PS 16'h03e8
`define LOSS_HIGH_PS 16'h1b58
`define LOSS_LOW_PS 16'h07d0

// ==========================================================
// Calibration divider: reference ticks per half period
`define CAL_HALF_DIV2 4'h1
`define CAL_HALF_DIV4 4'h2
`define CAL_HALF_DIV8 4'h4
`define CAL_HALF_DIV16 4'h8
`define CAL_CNT_ONE 4'h1
`define CAL_CNT_ZERO 4'h0

// ==========================================================
// Bus constants
`define HRESP_OKAY 1'b0
`define RDATA_ZERO 32'h0000_0000

`endif

// >>> pll_lock_pkg.sv
/*
 * Types for the PLL lock detect and calibration control block.
 * Assumes the constants header supplies all numeric values.
 */
package pll_lock_pkg;

    // ==========================================================
    // Control register layout, msb first
    typedef struct packed {
        logic dc_off;
        logic [1:0] lock_cnt;
        logic win_low;
        logic ld_dis;
        logic [1:0] cal_div;
        logic rsvd;
    } ctrl_t;

    // ==========================================================
    // Bus request held from address phase into data phase
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
    } bus_req_t;

    // ==========================================================
    // Lock detector states
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_ACQ = 3'b010,
        ST_LOCK = 3'b100
    } lock_state_t;

endpackage

// >>> cal_clock_divider.sv
/*
 * Divides reference clock ticks into the VCO calibration clock.
 * Assumes ref_tick is a one-cycle pulse per reference clock period,
 * synchronous to hclk.
 */
`timescale 1ns/1ps
`include "pll_lock_consts.svh"

module cal_clock_divider (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic ref_tick,
    input wire logic [1:0] div_sel,
    output logic cal_clk
);

    // ==========================================================
    // Divider state
    logic [3:0] half;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic clk_q;
    logic clk_d;

    // Half period in ticks for each ratio
    always_comb begin
        case (div_sel)
            2'h0: half = `CAL_HALF_DIV2;
            2'h1: half = `CAL_HALF_DIV4;
            2'h2: half = `CAL_HALF_DIV8;
            default: half = `CAL_HALF_DIV16;
        endcase
    end

    // Count ticks and toggle at each half period
    always_comb begin
        cnt_d = cnt_q;
        clk_d = clk_q;
        if (ce && ref_tick) begin
            if (cnt_q + `CAL_CNT_ONE >= half) begin
                cnt_d = `CAL_CNT_ZERO;
                clk_d = ~clk_q;
            end else begin
                cnt_d = 4'(cnt_q + `CAL_CNT_ONE);
            end
        end
    end

    // Register divider state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= `CAL_CNT_ZERO;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign cal_clk = clk_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    cal_toggle_a: assert property (
        (ce && ref_tick && cnt_q == half - `CAL_CNT_ONE && half == $past(half))
        |=> cal_clk != $past(cal_clk))
        else $error("cal clock missed its toggle");
    cal_ratio16_a: assert property (
        (div_sel == 2'h3) |-> half == `CAL_HALF_DIV16)
        else $error("divide by 16 half period wrong");
    cal_hold_a: assert property (
        !(ce && ref_tick) |=> cal_clk == $past(cal_clk))
        else $error("cal clock moved without a tick");
    cal_toggle_c: cover property (ce && ref_tick && clk_d != clk_q);

endmodule // cal_clock_divider

// >>> pll_lock_and_cal_control.sv
/*
 * PLL lock detect and calibration control with an AHB-Lite slave.
 * Assumes detector samples and reference ticks are synchronous to
 * hclk, and that the bus master issues single word transfers.
 * Status bits clear on read; an event in the clearing cycle wins.
 */
// Decided for this implementation: the AHB-Lite register port.
// Functional notes
// - Bit 7 adds dc offset to reference input
// - Lock needs 5/16/64/255 consecutive in-window cycles
// - Lock set when edge gap below window
// - Lock held until gap exceeds loss threshold
// - Window bit: 0 high range 3.5 ns
// - Disable bit 0 gives normal lock detection
// - Calibration clock divides reference by field ratio
// - Divider 2/4/8/16, reset selects 16
`timescale 1ns/1ps
`include "pll_lock_consts.svh"

module pll_lock_and_cal_control #(
    parameter logic [15:0] WIN_LOW_PS = `WIN_LOW_PS,
    parameter logic [15:0] LOSS_HIGH_PS = `LOSS_HIGH_PS,
    parameter logic [15:0] LOSS_LOW_PS = `LOSS_LOW_PS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pfd_sample,
    input wire logic [15:0] pfd_diff_ps,
    input wire logic ref_clk_tick,
    output logic digital_lock_flag,
    output logic ref_dc_offset_en,
    output logic cal_clk,
    output logic irq
);

    // ==========================================================
    // Register bank state
    pll_lock_pkg::ctrl_t ctrl_q;
    pll_lock_pkg::ctrl_t ctrl_d;
    pll_lock_pkg::bus_req_t req_q;
    pll_lock_pkg::bus_req_t req_d;
    logic [1:0] stat_q;
    logic [1:0] stat_d;
    logic [1:0] mask_q;
    logic [1:0] mask_d;
    logic [1:0] clr;
    logic [1:0] ev;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic irq_q;
    logic irq_d;
    logic accept;

    // ==========================================================
    // Lock detector state
    pll_lock_pkg::lock_state_t state_q;
    pll_lock_pkg::lock_state_t state_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] need;
    logic [15:0] win_ps;
    logic [15:0] loss_ps;
    logic flag_q;
    logic flag_d;
    logic in_win;

    // An access is taken only while the bus is ready and we are selected
    assign accept = hready && hsel && htrans[1];

    // Bus decode, register writes, read data and sticky status
    always_comb begin
        req_d = req_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        rdata_d = rdata_q;
        clr = 2'h0;
        stat_d = stat_q;
        irq_d = irq_q;
        if (ce) begin
            if (req_q.wr) begin
                case (req_q.addr)
                    `CTRL_ADDR: ctrl_d = pll_lock_pkg::ctrl_t'(
                        hwdata[7:0] & `CTRL_WMASK);
                    `IRQ_MASK_ADDR: mask_d = hwdata[1:0];
                    default: ;
                endcase
            end
            if (hready) begin
                req_d.wr = accept && hwrite;
                req_d.rd = accept && !hwrite;
                req_d.addr = {haddr[11:2], 2'b00};
            end
            // Control and mask read data use the next register values, so a read whose
            // address phase meets a write's data phase sees the new value
            if (accept && !hwrite) begin
                case ({haddr[11:2], 2'b00})
                    `CTRL_ADDR: rdata_d = {24'h00_0000, ctrl_d};
                    `IRQ_STAT_ADDR: begin
                        rdata_d = {30'h0000_0000, stat_q};
                        clr = stat_q;
                    end
                    `IRQ_MASK_ADDR: rdata_d = {30'h0000_0000, mask_d};
                    `LOCK_STATE_ADDR: rdata_d = {16'h0000, cnt_q,
                        5'h00, state_q == pll_lock_pkg::ST_OFF,
                        in_win, flag_q};
                    default: rdata_d = `RDATA_ZERO;
                endcase
            end
            stat_d = (stat_q & ~clr) | ev; // Set wins over clear
            irq_d = |(stat_d & mask_d);
        end
    end

    // Register bank flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
            ctrl_q <= pll_lock_pkg::ctrl_t'(`CTRL_RESET);
            mask_q <= `IRQ_RESET;
            stat_q <= `IRQ_RESET;
            rdata_q <= `RDATA_ZERO;
            irq_q <= 1'b0;
        end else begin
            req_q <= req_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = `HRESP_OKAY;
    assign hrdata = rdata_q;
    assign irq = irq_q;
    assign ref_dc_offset_en = ctrl_q.dc_off;
    assign digital_lock_flag = flag_q;

    // Window, loss threshold and cycle count selection
    always_comb begin
        win_ps = ctrl_q.win_low ? WIN_LOW_PS : `WIN_HIGH_PS;
        loss_ps = ctrl_q.win_low ? LOSS_LOW_PS : LOSS_HIGH_PS;
        case (ctrl_q.lock_cnt)
            2'h0: need = `LOCK_CNT_SEL0;
            2'h1: need = `LOCK_CNT_SEL1;
            2'h2: need = `LOCK_CNT_SEL2;
            default: need = `LOCK_CNT_SEL3;
        endcase
        in_win = pfd_diff_ps < win_ps;
    end

    // Lock detector next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        ev = 2'h0;
        if (ce) begin
            case (state_q)
                pll_lock_pkg::ST_OFF: begin
                    if (!ctrl_q.ld_dis) begin
                        state_d = pll_lock_pkg::ST_ACQ;
                    end
                end
                pll_lock_pkg::ST_ACQ: begin
                    if (ctrl_q.ld_dis) begin
                        state_d = pll_lock_pkg::ST_OFF;
                        cnt_d = `CNT_ZERO;
                    end else if (pfd_sample && in_win) begin
                        // Count stops at need, so 255 cannot wrap
                        cnt_d = 8'(cnt_q + `CNT_ONE);
                        if (cnt_q + `CNT_ONE >= need) begin
                            state_d = pll_lock_pkg::ST_LOCK;
                            ev = `IRQ_ACQ;
                        end
                    end else if (pfd_sample) begin
                        cnt_d = `CNT_ZERO;
                    end
                end
                pll_lock_pkg::ST_LOCK: begin
                    if (ctrl_q.ld_dis) begin
                        state_d = pll_lock_pkg::ST_OFF;
                        cnt_d = `CNT_ZERO;
                    end else if (pfd_sample && pfd_diff_ps > loss_ps) begin
                        state_d = pll_lock_pkg::ST_ACQ;
                        cnt_d = `CNT_ZERO;
                        ev = `IRQ_LOSS;
                    end
                end
                default: begin
                    state_d = pll_lock_pkg::ST_OFF;
                    cnt_d = `CNT_ZERO;
                end
            endcase
        end
        // Flag follows the next state, so it rises on the Nth sample edge
        flag_d = state_d == pll_lock_pkg::ST_LOCK;
    end

    // Lock detector flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= pll_lock_pkg::ST_ACQ;
            cnt_q <= `CNT_ZERO;
            flag_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    // ==========================================================
    // Calibration clock divider
    cal_clock_divider u_cal_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .ref_tick(ref_clk_tick),
        .div_sel(ctrl_q.cal_div),
        .cal_clk(cal_clk)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    dc_offset_write_a: assert property (
        (ce && req_q.wr && req_q.addr == `CTRL_ADDR)
        |=> ref_dc_offset_en == $past(hwdata[7]))
        else $error("dc offset enable not taken from write");
    lock_count_a: assert property (
        $rose(digital_lock_flag)
        |-> $past(cnt_q) + `CNT_ONE == $past(need))
        else $error("lock asserted at wrong cycle count");
    lock_window_a: assert property (
        $rose(digital_lock_flag) |-> $past(pfd_sample && in_win))
        else $error("lock asserted without in-window cycle");
    lock_hold_a: assert property (
        (ce && flag_q && !ctrl_q.ld_dis
         && !(pfd_sample && pfd_diff_ps > loss_ps)) |=> flag_q)
        else $error("lock dropped inside loss threshold");
    high_range_a: assert property (
        (ce && state_q == pll_lock_pkg::ST_ACQ && !ctrl_q.ld_dis
         && !ctrl_q.win_low && pfd_sample && pfd_diff_ps == 16'h0dab
         && cnt_q + `CNT_ONE < need) |=> cnt_q == $past(cnt_q) + `CNT_ONE)
        else $error("high range window not 3500 ps");
    normal_detect_a: assert property (
        (ce && !ctrl_q.ld_dis && state_q == pll_lock_pkg::ST_OFF)
        |=> state_q == pll_lock_pkg::ST_ACQ)
        else $error("detector stayed off when enabled");
    disable_clear_a: assert property (
        (ce && ctrl_q.ld_dis) |=> !digital_lock_flag ##1 !digital_lock_flag)
        else $error("lock flag set while disabled");
    restart_count_a: assert property (
        (ce && state_q == pll_lock_pkg::ST_ACQ && pfd_sample && !in_win)
        |=> cnt_q == `CNT_ZERO)
        else $error("out of window cycle kept the count");

    // ==========================================================
    // Early lock, loss, low range, disable and status hazards
    early_lock_a: assert property (
        (ce && state_q == pll_lock_pkg::ST_ACQ && !ctrl_q.ld_dis
         && cnt_q + `CNT_ONE < need) |=> !digital_lock_flag)
        else $error("lock asserted before the cycle count");
    loss_drop_a: assert property (
        (ce && flag_q && !ctrl_q.ld_dis && pfd_sample
         && pfd_diff_ps > loss_ps) |=> !digital_lock_flag)
        else $error("lock kept beyond loss threshold");
    low_range_a: assert property (
        (ce && state_q == pll_lock_pkg::ST_ACQ && !ctrl_q.ld_dis
         && ctrl_q.win_low && pfd_sample && pfd_diff_ps >= WIN_LOW_PS)
        |=> cnt_q == `CNT_ZERO && !digital_lock_flag)
        else $error("low range window accepted a wide gap");
    off_hold_a: assert property (
        (ce && state_q == pll_lock_pkg::ST_OFF && ctrl_q.ld_dis)
        |=> cnt_q == `CNT_ZERO && !digital_lock_flag)
        else $error("disabled detector kept evaluating");
    dc_offset_hold_a: assert property (
        !(ce && req_q.wr && req_q.addr == `CTRL_ADDR)
        |=> $stable(ref_dc_offset_en))
        else $error("dc offset enable moved without a write");
    stat_set_wins_a: assert property (
        (ce && (ev & clr) != 2'h0)
        |=> (stat_q & $past(ev & clr)) == $past(ev & clr))
        else $error("status event lost to a clearing read");

    lock_gain_c: cover property ($rose(digital_lock_flag));
    lock_loss_c: cover property ($fell(digital_lock_flag) && !ctrl_q.ld_dis);
    irq_c: cover property ($rose(irq));
    stat_clear_c: cover property (accept && !hwrite && clr != 2'h0);

endmodule // pll_lock_and_cal_control

// >>> tb_pll_lock_and_cal_control.sv
/*
 * Self-checking testbench for the PLL lock detect and calibration
 * control block: bus reads and writes, lock counts, window, loss
 * threshold, disable, interrupt and calibration divider.
 * Assumes the constants header and the design files are compiled first.
 */
`timescale 1ns/1ps
`include "pll_lock_consts.svh"

module tb_pll_lock_and_cal_control;
    logic hclk, hresetn, hsel, hwrite, pfd_sample, ref_clk_tick, ce;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] pfd_diff_ps;
    logic hreadyout, hresp, digital_lock_flag, ref_dc_offset_en;
    logic cal_clk, irq;
    int fails, checks;
    int cnt[4] = '{`LOCK_CNT_SEL0, `LOCK_CNT_SEL1, `LOCK_CNT_SEL2,
                   `LOCK_CNT_SEL3};

    // ==========================================================
    // Design under test, hready looped back from the one slave
    pll_lock_and_cal_control u_pll_lock_and_cal_control (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pfd_sample(pfd_sample),
        .pfd_diff_ps(pfd_diff_ps), .ref_clk_tick(ref_clk_tick),
        .digital_lock_flag(digital_lock_flag),
        .ref_dc_offset_en(ref_dc_offset_en), .cal_clk(cal_clk), .irq(irq)
    );

    // ==========================================================
    // Clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        #1_000_000;
        fails++;
        results();
    end

    // ==========================================================
    // Comparison, verdict and bus tasks
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Waits for hready high at a rising edge, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            results();
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0_0000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        @(posedge hclk);
    endtask

    task automatic rdc(input string name, input logic [11:0] a,
                       input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk(name, exp, x);
    endtask

    // Back-to-back detector samples, then flag settled
    task automatic samp(input int n, input logic [15:0] d);
        pfd_sample <= 1'b1;
        pfd_diff_ps <= d;
        repeat (n) @(posedge hclk);
        pfd_sample <= 1'b0;
        @(posedge hclk);
    endtask

    // Reference ticks between two calibration clock rises
    task automatic calper(input int exp);
        int t, r;
        logic p;
        t = 0;
        r = 0;
        p = cal_clk;
        for (int i = 0; i < 100 && r < 2; i++) begin
            ref_clk_tick <= 1'b1;
            @(posedge hclk);
            ref_clk_tick <= 1'b0;
            @(posedge hclk);
            if (r == 1)
                t++;
            if (cal_clk && !p)
                r++;
            p = cal_clk;
        end
        chk("cal period", exp, t);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, pfd_sample, ref_clk_tick} = 4'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        pfd_diff_ps = 16'h0000;
        ce = 1'b1;
        fails = 0;
        checks = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values and unmapped place
        rdc("ctrl", `CTRL_ADDR, 32'h0000_0006);
        rdc("status", `IRQ_STAT_ADDR, 32'h0000_0000);
        rdc("mask", `IRQ_MASK_ADDR, 32'h0000_0000);
        rdc("unmapped", 12'h100, 32'h0000_0000);
        chk("dc offset", 32'h0000_0000, ref_dc_offset_en);
        // Dc offset bit, bit 0 not writable
        wr(`CTRL_ADDR, 32'h0000_0087);
        chk("dc offset", 32'h0000_0001, ref_dc_offset_en);
        rdc("ctrl", `CTRL_ADDR, 32'h0000_0086);
        wr(`CTRL_ADDR, 32'h0000_0006);
        chk("dc offset", 32'h0000_0000, ref_dc_offset_en);
        wr(`IRQ_MASK_ADDR, 32'h0000_0003);
        // Every count code: lock at the Nth sample, hold, loss
        for (int s = 0; s < 4; s++) begin
            wr(`CTRL_ADDR, 32'(s << 5) | 32'h0000_0006);
            samp(cnt[s] - 1, 16'h0dab);
            chk("lock flag", 32'h0000_0000, digital_lock_flag);
            samp(1, 16'h0dab);
            chk("lock flag", 32'h0000_0001, digital_lock_flag);
            samp(1, 16'h1b57);
            chk("lock flag", 32'h0000_0001, digital_lock_flag);
            samp(1, 16'h1b59);
            chk("lock flag", 32'h0000_0000, digital_lock_flag);
            chk("irq", 32'h0000_0001, irq);
            rdc("status", `IRQ_STAT_ADDR, 32'h0000_0003);
            @(posedge hclk);
            chk("irq", 32'h0000_0000, irq);
        end
        // Out-of-window sample restarts the count; masked irq
        wr(`IRQ_MASK_ADDR, 32'h0000_0000);
        wr(`CTRL_ADDR, 32'h0000_0006);
        samp(4, 16'h0064);
        samp(1, 16'h0dac);
        samp(4, 16'h0064);
        chk("lock flag", 32'h0000_0000, digital_lock_flag);
        samp(1, 16'h0064);
        chk("lock flag", 32'h0000_0001, digital_lock_flag);
        chk("irq", 32'h0000_0000, irq);
        rdc("status", `IRQ_STAT_ADDR, 32'h0000_0001);
        samp(1, 16'h1b59);
        // Low range window rejects 1500 ps
        wr(`CTRL_ADDR, 32'h0000_0016);
        samp(5, 16'h05dc);
        chk("lock flag", 32'h0000_0000, digital_lock_flag);
        samp(5, 16'h0064);
        chk("lock flag", 32'h0000_0001, digital_lock_flag);
        // Disable drops the flag and stops evaluation
        wr(`CTRL_ADDR, 32'h0000_001e);
        @(posedge hclk);
        chk("lock flag", 32'h0000_0000, digital_lock_flag);
        samp(5, 16'h0064);
        chk("lock flag", 32'h0000_0000, digital_lock_flag);
        wr(`CTRL_ADDR, 32'h0000_0006);
        samp(5, 16'h0064);
        chk("lock flag", 32'h0000_0001, digital_lock_flag);
        // Clock enable low freezes the flag through a loss sample
        ce <= 1'b0;
        samp(1, 16'h1b59);
        chk("frozen flag", 32'h0000_0001, digital_lock_flag);
        ce <= 1'b1;
        // Calibration divider codes
        for (int s = 3; s >= 0; s--) begin
            wr(`CTRL_ADDR, 32'(s << 1));
            calper(2 << s);
        end
        results();
    end
endmodule // tb_pll_lock_and_cal_control
